// ==== sdram_cfg_pkg.sv ====
// Purpose: shared constants and types for the sdram bank configuration block
// Assumes: 32-bit apb, word-aligned registers, 100 MHz clock
// Notes:   offsets and field layouts are local choices
package sdram_cfg_pkg;
	localparam int          NUM_BANKS      = 8;
	localparam int          ADDR_W         = 12;
	localparam int          CLK_MHZ        = 100;
	// register byte offsets
	localparam logic [11:0] OFS_TIMING     = 12'h000;
	localparam logic [11:0] OFS_REFRESH    = 12'h004;
	localparam logic [11:0] OFS_SCRUB      = 12'h008;
	localparam logic [11:0] OFS_STATUS     = 12'h00C;
	localparam logic [11:0] OFS_BANK0      = 12'h010;
	localparam logic [11:0] OFS_LOOKUP     = 12'h030;
	localparam logic [11:0] OFS_LOOKUP_RES = 12'h034;
	// timing field: cas3[7] trc[6:4] trcd[3] trp[2] tras[1:0]
	localparam logic [7:0]  TIMING_SLOWEST = 8'hAF;
	// refresh select: 0 -> 15.5us, 1 -> 7.75us, 2 -> 3.75us
	localparam logic [1:0]  REFRESH_RESET  = 2'h1;
	localparam int          REF_15_5_NS    = 15500;
	localparam int          REF_7_75_NS    = 7750;
	localparam int          REF_3_75_NS    = 3750;
	localparam int          REF_15_5_CYC   = REF_15_5_NS * CLK_MHZ / 1000;
	localparam int          REF_7_75_CYC   = REF_7_75_NS * CLK_MHZ / 1000;
	localparam int          REF_3_75_CYC   = REF_3_75_NS * CLK_MHZ / 1000;
	localparam int          REF_CNT_W      = 11;
	// bank register: enable[31] base[23:16] (addr[31:24]) size[3:0]
	localparam int          BANK_EN_BIT    = 31;
	localparam int          BANK_BASE_LSB  = 16;
	localparam int          BANK_SIZE_LSB  = 0;
	localparam logic [3:0]  SIZE_RESET     = 4'h0;
	localparam int          INT_BANKS      = 4;

	typedef struct packed {
		logic       enable;
		logic [7:0] base;
		logic [3:0] size;
	} bank_cfg_s;

	typedef struct packed {
		logic       hit;
		logic [2:0] bank;
		logic [1:0] ibank;
		logic [12:0] row;
		logic [11:0] col;
	} xlate_s;
endpackage

// ==== sdram_bank_decode.sv ====
// Purpose: one bank's address decode and row/column/bank split
// Assumes: size codes 1..15 map 32MB..2GB, four internal banks
// Notes:   purely combinational, two instances per bank (cpu and lookup)
module sdram_bank_decode (
	input  wire sdram_cfg_pkg::bank_cfg_s cfg_i,
	input  wire logic [31:0]              addr_i,
	output logic                          hit_o,
	output logic [1:0]                    ibank_o,
	output logic [12:0]                   row_o,
	output logic [11:0]                   col_o
);
	logic [7:0]  mask;
	logic [3:0]  lg;
	logic [31:0] word;

	always_comb
	begin
		// size as log2 of 32MB units
		lg = 4'h0;
		case (cfg_i.size)
			4'h1: lg = 4'h0;
			4'h2, 4'h3: lg = 4'h1;
			4'h4, 4'h5, 4'h6: lg = 4'h2;
			4'h7, 4'h8, 4'h9: lg = 4'h3;
			4'hA, 4'hB, 4'hC: lg = 4'h4;
			4'hD, 4'hE: lg = 4'h5;
			default: lg = 4'h6;
		endcase
		// base steps are 16MB, so one more masked bit than lg
		mask = 8'hFF << (lg + 4'h1);
		// zero size or disabled never claims
		hit_o = cfg_i.enable && (cfg_i.size != 4'h0)
			&& ((addr_i[31:24] & mask[7:0] & 8'hFF)
			== (cfg_i.base & mask));
		// 8-byte words; narrow devices have more columns
		word = {3'h0, addr_i[31:3]};
		col_o = (cfg_i.size == 4'h1 || cfg_i.size == 4'h3
			|| cfg_i.size == 4'h6) ? {3'h0, word[8:0]}
			: {2'h0, word[9:0]};
		ibank_o = word[11:10]; // four internal banks
		row_o = word[24:12] & ~(13'h1FFF << (lg + 4'h7));
	end
endmodule

// ==== sdram_bank_config.sv ====
// Purpose: sdram speed, refresh and per-bank configuration with decode
// Assumes: apb slave on clk_i, software follows the init sequence
// Notes:   outputs registered; lookup port lets software test decode
// Operation
// - one speed attribute register serves all banks
// - one refresh period setting serves all banks
// - each bank has its own size, base and enable
// - reset loads slowest speed attributes
// - reset loads 7.75 us refresh per row
// - reset clears every bank size to zero
// - size drives range decode and row/column/bank mapping
// - scrubbing covers only banks with non-zero size
// - only four internal bank devices are supported
//
// Chosen here: register access over APB and the placing of the registers.
module sdram_bank_config #(
	parameter int NUM_BANKS = sdram_cfg_pkg::NUM_BANKS
) (
	input  wire logic          clk_i,
	input  wire logic          nrst_i,
	input  wire logic          psel_i,
	input  wire logic          penable_i,
	input  wire logic          pwrite_i,
	input  wire logic [11:0]   paddr_i,
	input  wire logic [31:0]   pwdata_i,
	output logic      [31:0]   prdata_o,
	output logic               pready_o,
	output logic               pslverr_o,
	input  wire logic [31:0]   cpu_addr_i,
	output sdram_cfg_pkg::xlate_s xlate_o,
	output logic      [7:0]    timing_o,
	output logic      [7:0]    scrub_mask_o,
	output logic               refresh_req_o
);
	////////////////////////////////////////////////////////////////////
	// register state
	logic [7:0]  timing, next_timing;
	logic [1:0]  refresh_sel, next_refresh_sel;
	logic        scrub_en, next_scrub_en;
	sdram_cfg_pkg::bank_cfg_s [NUM_BANKS-1:0] bank, next_bank;
	logic [31:0] lookup_addr, next_lookup_addr;
	logic [31:0] rdata, next_rdata;
	logic        ready, next_ready;
	logic        slverr, next_slverr;
	logic [3:0]  idx;
	logic        bank_sel;
	logic        take;
	logic        wr_en;

	////////////////////////////////////////////////////////////////////
	// decode per bank
	logic [NUM_BANKS-1:0] hit_cpu, hit_lk;
	logic [1:0]  ib_cpu [NUM_BANKS];
	logic [12:0] row_cpu [NUM_BANKS];
	logic [11:0] col_cpu [NUM_BANKS];
	logic [1:0]  ib_lk [NUM_BANKS];
	logic [12:0] row_lk [NUM_BANKS];
	logic [11:0] col_lk [NUM_BANKS];

	genvar g;
	generate
		for (g = 0; g < NUM_BANKS; g++)
		begin : g_bank
			sdram_bank_decode u_cpu (
				.cfg_i  (bank[g]),
				.addr_i (cpu_addr_i),
				.hit_o  (hit_cpu[g]),
				.ibank_o(ib_cpu[g]),
				.row_o  (row_cpu[g]),
				.col_o  (col_cpu[g])
			);
			sdram_bank_decode u_lk (
				.cfg_i  (bank[g]),
				.addr_i (lookup_addr),
				.hit_o  (hit_lk[g]),
				.ibank_o(ib_lk[g]),
				.row_o  (row_lk[g]),
				.col_o  (col_lk[g])
			);
		end
	endgenerate

	sdram_cfg_pkg::xlate_s x_cpu, x_lk, next_xlate;
	logic [NUM_BANKS-1:0] sized;

	always_comb
	begin
		x_cpu = '0;
		x_lk = '0;
		for (int i = NUM_BANKS - 1; i >= 0; i--)
		begin
			sized[i] = bank[i].size != 4'h0;
			if (hit_cpu[i])
			begin
				x_cpu = {1'b1, 3'(i), ib_cpu[i], row_cpu[i],
					col_cpu[i]};
			end
			if (hit_lk[i])
			begin
				x_lk = {1'b1, 3'(i), ib_lk[i], row_lk[i], col_lk[i]};
			end
		end
		next_xlate = x_cpu;
	end

	////////////////////////////////////////////////////////////////////
	// apb register access
	always_comb
	begin
		next_timing = timing;
		next_refresh_sel = refresh_sel;
		next_scrub_en = scrub_en;
		next_bank = bank;
		next_lookup_addr = lookup_addr;
		next_rdata = rdata;
		next_ready = 1'b0;
		next_slverr = 1'b0;
		idx = 4'(paddr_i[11:2] - sdram_cfg_pkg::OFS_BANK0[11:2]);
		bank_sel = paddr_i >= sdram_cfg_pkg::OFS_BANK0
			&& paddr_i < sdram_cfg_pkg::OFS_LOOKUP
			&& paddr_i[1:0] == 2'h0;
		// setup edge answers, access edge commits the write
		take = psel_i && !ready;
		wr_en = psel_i && penable_i && ready && pwrite_i;
		if (take)
		begin
			next_ready = 1'b1;
			next_rdata = 32'h0000_0000;
		end
		if (psel_i)
		begin
			case (paddr_i)
				sdram_cfg_pkg::OFS_TIMING:
				begin
					if (take)
						next_rdata = {24'h0, timing};
					if (wr_en)
						next_timing = pwdata_i[7:0];
				end
				sdram_cfg_pkg::OFS_REFRESH:
				begin
					if (take)
						next_rdata = {30'h0, refresh_sel};
					if (wr_en && pwdata_i[1:0] != 2'h3)
						next_refresh_sel = pwdata_i[1:0];
				end
				sdram_cfg_pkg::OFS_SCRUB:
				begin
					if (take)
						next_rdata = {31'h0, scrub_en};
					if (wr_en)
						next_scrub_en = pwdata_i[0];
				end
				sdram_cfg_pkg::OFS_STATUS:
				begin
					if (take)
						next_rdata = {16'h0, 8'(hit_lk), 8'(sized)};
				end
				sdram_cfg_pkg::OFS_LOOKUP:
				begin
					if (take)
						next_rdata = lookup_addr;
					if (wr_en)
						next_lookup_addr = pwdata_i;
				end
				sdram_cfg_pkg::OFS_LOOKUP_RES:
				begin
					if (take)
						next_rdata = {1'b0, x_lk};
				end
				default:
				begin
					if (bank_sel && idx < 4'(NUM_BANKS))
					begin
						if (take)
							next_rdata = {bank[idx].enable, 7'h0,
								bank[idx].base, 12'h0, bank[idx].size};
						if (wr_en)
							next_bank[idx] = {pwdata_i[31],
								pwdata_i[23:16], pwdata_i[3:0]};
					end
					else if (take)
						next_slverr = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			timing <= sdram_cfg_pkg::TIMING_SLOWEST;
			refresh_sel <= sdram_cfg_pkg::REFRESH_RESET;
			scrub_en <= 1'b0;
			for (int i = 0; i < NUM_BANKS; i++)
				bank[i] <= '0;
			lookup_addr <= 32'h0000_0000;
			rdata <= 32'h0000_0000;
			ready <= 1'b0;
			slverr <= 1'b0;
		end
		else
		begin
			timing <= next_timing;
			refresh_sel <= next_refresh_sel;
			scrub_en <= next_scrub_en;
			bank <= next_bank;
			lookup_addr <= next_lookup_addr;
			rdata <= next_rdata;
			ready <= next_ready;
			slverr <= next_slverr;
		end
	end

	////////////////////////////////////////////////////////////////////
	// refresh timer shared by all banks
	logic [10:0] ref_cnt, next_ref_cnt, ref_limit;
	logic        ref_req, next_ref_req;
	logic [7:0]  scrub_mask, next_scrub_mask;
	sdram_cfg_pkg::xlate_s xlate;

	always_comb
	begin
		case (refresh_sel)
			2'h0: ref_limit = 11'(sdram_cfg_pkg::REF_15_5_CYC - 1);
			2'h2: ref_limit = 11'(sdram_cfg_pkg::REF_3_75_CYC - 1);
			default: ref_limit = 11'(sdram_cfg_pkg::REF_7_75_CYC - 1);
		endcase
		next_ref_req = ref_cnt >= ref_limit;
		next_ref_cnt = next_ref_req ? 11'h000 : ref_cnt + 11'h001;
		next_scrub_mask = scrub_en ? 8'(sized) : 8'h00;
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			ref_cnt <= 11'h000;
			ref_req <= 1'b0;
			scrub_mask <= 8'h00;
			xlate <= '0;
		end
		else
		begin
			ref_cnt <= next_ref_cnt;
			ref_req <= next_ref_req;
			scrub_mask <= next_scrub_mask;
			xlate <= next_xlate;
		end
	end

	assign prdata_o = rdata;
	assign pready_o = ready;
	assign pslverr_o = slverr;
	assign timing_o = timing;
	assign refresh_req_o = ref_req;
	assign scrub_mask_o = scrub_mask;
	assign xlate_o = xlate;
endmodule

// ==== sdram_bank_config_sva.sv ====
// Purpose: port checks for the sdram bank configuration
// Assumes: wait-free apb answer, one clock
// Notes:   bind follows the module
module sdram_bank_config_sva (
	input wire logic                  clk_i,
	input wire logic                  nrst_i,
	input wire logic                  psel_i,
	input wire logic                  penable_i,
	input wire logic [31:0]           prdata_o,
	input wire logic                  pready_o,
	input wire logic                  pslverr_o,
	input wire sdram_cfg_pkg::xlate_s xlate_o,
	input wire logic [7:0]            timing_o,
	input wire logic [7:0]            scrub_mask_o,
	input wire logic                  refresh_req_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);
	sequence s_setup; psel_i && !penable_i; endsequence
	sequence s_done; psel_i && penable_i && pready_o; endsequence
	sequence s_quiet; !psel_i ##1 !psel_i; endsequence
	property p_answer; s_setup |=> s_done; endproperty
	a_answer: assert property (p_answer)
		else $error("setup not answered");
	property p_pulse; pready_o |=> !pready_o; endproperty
	a_pulse: assert property (p_pulse)
		else $error("ready held too long");
	property p_idle; !psel_i |=> !pready_o; endproperty
	a_idle: assert property (p_idle)
		else $error("ready without request");
	property p_err; pslverr_o |-> pready_o && prdata_o == 32'h0; endproperty
	a_err: assert property (p_err)
		else $error("error answer malformed");
	property p_slow;
		$rose(nrst_i) |-> timing_o == sdram_cfg_pkg::TIMING_SLOWEST;
	endproperty
	a_slow: assert property (p_slow)
		else $error("speed not slowest after reset");
	property p_nohit; $rose(nrst_i) |-> !xlate_o.hit [*2]; endproperty
	a_nohit: assert property (p_nohit)
		else $error("hit with cleared sizes");
	property p_noscr; $rose(nrst_i) |-> scrub_mask_o == 8'h00; endproperty
	a_noscr: assert property (p_noscr)
		else $error("scrub mask set after reset");
	property p_refgap; refresh_req_o |=> !refresh_req_o [*8]; endproperty
	a_refgap: assert property (p_refgap)
		else $error("refresh requests too close");
	property p_hold; s_quiet |-> $stable(timing_o); endproperty
	a_hold: assert property (p_hold)
		else $error("speed changed without write");
endmodule
bind sdram_bank_config sdram_bank_config_sva chk (.clk_i, .nrst_i,
	.psel_i, .penable_i, .prdata_o, .pready_o, .pslverr_o, .xlate_o,
	.timing_o, .scrub_mask_o, .refresh_req_o);

// ==== sdram_side_model.sv ====
// Purpose: sdram side stand-in timing refresh requests
// Assumes: each request is a one-cycle pulse
// Notes:   gap_o is the last request spacing in cycles
module sdram_side_model (
	input  wire logic clk_i,
	input  wire logic refresh_req_i,
	output int        gap_o
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int         IBANKS   = 4;
	localparam logic [2:0] SPD_SLOT = 3'h0;
	int cnt = 0;
	always @(posedge clk_i)
	begin
		cnt <= refresh_req_i ? 0 : cnt + 1;
		if (refresh_req_i)
			gap_o <= cnt + 1;
	end
endmodule

// ==== tb_top.sv ====
// Purpose: self-checking bench for the sdram bank configuration
// Assumes: wait-free apb answer, pulsed refresh request
// Notes:   register image kept in m and compared on reads
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                  clk_i = 1'h0;
	logic                  nrst_i = 1'h0;
	logic                  psel_i = 1'h0;
	logic                  penable_i = 1'h0;
	logic                  pwrite_i = 1'h0;
	logic [11:0]           paddr_i = 12'h0;
	logic [31:0]           pwdata_i = 32'h0;
	logic [31:0]           cpu_addr_i = 32'h0;
	logic [31:0]           prdata_o;
	logic                  pready_o;
	logic                  pslverr_o;
	sdram_cfg_pkg::xlate_s xlate_o;
	logic [7:0]            timing_o;
	logic [7:0]            scrub_mask_o;
	logic                  refresh_req_o;
	logic [31:0]           m [16];
	logic [31:0]           lfsr = 32'h0461;
	logic [31:0]           r;
	logic [31:0]           p;
	logic                  e;
	int                    gap;
	int                    miscompares = 0;
	int                    samples_checked = 0;
	int                    per [4] = '{1550, 775, 375, 0};
	int                    sel [4] = '{1, 2, 0, 3};
	sdram_bank_config dut (.clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i,
		.paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .cpu_addr_i,
		.xlate_o, .timing_o, .scrub_mask_o, .refresh_req_o);
	sdram_side_model sdm (.clk_i, .refresh_req_i(refresh_req_o), .gap_o(gap));
	initial forever #5 clk_i = ~clk_i;
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	task automatic chk(input logic [31:0] s, x, input string n);
		samples_checked++;
		if (s !== x)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic conclude();
		$display("checked %0d mismatched %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel_i <= 1'h1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'h1;
		for (int k = 0; k < 20; k++)
		begin
			@(posedge clk_i);
			if (pready_o === 1'h1)
				break;
		end
		r = prdata_o;
		e = pslverr_o;
		if (pready_o !== 1'h1)
			miscompares++;
		if (pready_o !== 1'h1)
			conclude();
		psel_i <= 1'h0;
		penable_i <= 1'h0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
		if (a[5:2] == 4'h0)
			m[0] = d & 32'hFF;
		if (a[5:2] == 4'h1 && d[1:0] != 2'h3)
			m[1] = d & 32'h3;
		if (a[5:2] == 4'h2)
			m[2] = d & 32'h1;
		if (a[5:2] inside {[4:11]})
			m[a[5:2]] = d & 32'h80FF000F;
	endtask
	task automatic rd(input logic [11:0] a);
		apb(1'h0, a, 32'h0);
		chk(r, m[a[5:2]], "register");
	endtask
	task automatic look(input logic [31:0] a, input logic h, input int b);
		cpu_addr_i <= a;
		repeat (2) @(posedge clk_i);
		chk(32'(xlate_o.hit), 32'(h), "hit");
		if (h)
			chk(32'(xlate_o.bank), 32'(b), "bank");
		if (h)
			chk(32'(xlate_o.ibank), 32'(a[14:13]), "ibank");
		if (h)
			chk(32'(xlate_o.col), 32'(a[11:3]), "column");
	endtask
	task automatic pulse();
		int k;
		for (k = 0; k < 4000 && refresh_req_o !== 1'h1; k++)
			@(posedge clk_i);
		if (k == 4000)
			miscompares++;
		if (k == 4000)
			conclude();
		@(posedge clk_i);
	endtask
	initial
	begin
		foreach (m[i])
			m[i] = 32'h0;
		m[0] = 32'hAF;
		m[1] = 32'h1;
		repeat (6) @(posedge clk_i);
		nrst_i <= 1'h1;
		@(posedge clk_i);
		for (int i = 0; i < 12; i++)
			if (i != 3)
				rd(12'(4 * i));
		wr(12'h000, rnd());
		chk(32'(timing_o), m[0], "speed");
		$display("test reset and speed done");
		foreach (sel[j])
		begin
			wr(12'h004, 32'(sel[j]));
			pulse();
			pulse();
			chk(32'(gap), 32'(per[m[1][1:0]]), "refresh");
			rd(12'h004);
		end
		apb(1'h1, 12'h100, rnd());
		chk(32'(e), 32'h1, "slverr");
		apb(1'h0, 12'h100, 32'h0);
		chk(r, 32'h0, "unmapped");
		$display("test refresh and unmapped done");
		for (int i = 0; i < 8; i++)
		begin
			wr(12'(16 + 4 * i), 32'h1);
			look(rnd() & 32'h01FFFFF8, 1'h0, i);
			wr(12'(16 + 4 * i), 32'h80000001);
			rd(12'(16 + 4 * i));
			look(rnd() & 32'h01FFFFF8, 1'h1, i);
			wr(12'h030, 32'h00800000);
			apb(1'h0, 12'h034, 32'h0);
			chk(32'(r[30:27]), {28'h0, 1'h1, 3'(i)}, "lookup");
			look(32'hF0000000, 1'h0, i);
			wr(12'(16 + 4 * i), 32'h80000000);
			look(32'h00001000, 1'h0, i);
			wr(12'(16 + 4 * i), 32'h1);
		end
		$display("test bank decode done");
		p = rnd() & 32'hFF;
		for (int i = 0; i < 8; i++)
			if (!p[i])
				wr(12'(16 + 4 * i), 32'h0);
		wr(12'h008, 32'h0);
		chk(32'(scrub_mask_o), 32'h0, "scrub off");
		wr(12'h008, 32'h1);
		@(posedge clk_i);
		chk(32'(scrub_mask_o), p, "scrub on");
		apb(1'h0, 12'h00C, 32'h0);
		chk(r & 32'hFF, p, "status");
		$display("test scrub done");
		conclude();
	end
endmodule
